/* File: rtl/sq_pkg.sv */
package sq_pkg;
	// ----------------------------------------
	// Status codes reported to the driver
	// ----------------------------------------
	localparam logic [7:0] ST_BUS_ERR = 8'h00;
	localparam logic [7:0] ST_SR_ADDR = 8'h60;
	localparam logic [7:0] ST_SR_ARB = 8'h68;
	localparam logic [7:0] ST_GC_ADDR = 8'h70;
	localparam logic [7:0] ST_GC_ARB = 8'h78;
	localparam logic [7:0] ST_SR_ACK = 8'h80;
	localparam logic [7:0] ST_SR_NACK = 8'h88;
	localparam logic [7:0] ST_GC_ACK = 8'h90;
	localparam logic [7:0] ST_GC_NACK = 8'h98;
	localparam logic [7:0] ST_STOP = 8'ha0;
	localparam logic [7:0] ST_ST_ADDR = 8'ha8;
	localparam logic [7:0] ST_ST_ARB = 8'hb0;
	localparam logic [7:0] ST_ST_ACK = 8'hb8;
	localparam logic [7:0] ST_ST_NACK = 8'hc0;
	localparam logic [7:0] ST_ST_LAST = 8'hc8;
	localparam logic [7:0] ST_NO_INFO = 8'hf8;
	// ----------------------------------------
	// Control bit positions and write values
	// ----------------------------------------
	localparam int CB_ACK = 2;
	localparam int CB_FLAG = 3;
	localparam int CB_HALT = 4;
	localparam int CB_BEGIN = 5;
	localparam int CB_EN = 6;
	localparam logic [7:0] CV_NONE = 8'h00;
	localparam logic [7:0] CV_ACK = 8'h04;
	localparam logic [7:0] CV_FLAG = 8'h08;
	localparam logic [7:0] CV_AA_FLAG = 8'h0c;
	localparam logic [7:0] CV_HALT_AA = 8'h14;
	localparam logic [7:0] CV_BEGIN_AA = 8'h24;
	localparam logic [7:0] CV_INIT = 8'h44;
	// General call address byte
	localparam logic [7:0] GC_BYTE = 8'h00;
	// ----------------------------------------
	// Driver-side AXI4-Lite map
	// ----------------------------------------
	localparam logic [3:0] A_CTRL = 4'h0;
	localparam logic [3:0] A_STAT = 4'h4;
	localparam logic [3:0] A_TXD = 4'h8;
	localparam logic [3:0] A_RXD = 4'hc;
	localparam logic [15:0] HCTRL_RST = 16'h0000;
	localparam int HC_EN = 0;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

/* File: rtl/sq_reg_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Register port between the bus controller and its driver
interface sq_reg_if;
	logic set_stb; // Write strobe for the bit setter
	logic clr_stb; // Write strobe for the bit clearer
	logic buf_stb; // Write strobe for the byte buffer
	logic [7:0] wdata; // Data for any of the strobes
	logic [7:0] status; // Current status code
	logic [7:0] rbyte; // Byte buffer read-back
	logic [7:0] ctrl; // Control bits read-back
	logic flag; // State-change flag
	modport dev (input set_stb, clr_stb, buf_stb, wdata, output status, rbyte, ctrl, flag);
	modport drv (output set_stb, clr_stb, buf_stb, wdata, input status, rbyte, ctrl, flag);
endinterface
`default_nettype wire

/* File: rtl/sq_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module sq_pin_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Raw pin
	input wire logic pin_i,
	// Synchronised level and edges
	output logic lvl,
	output logic rise,
	output logic fall
);
	logic s1_r; // First stage, read only by s2_r
	logic s2_r; // Stable level
	logic s3_r; // Previous level for edges

	// ----------------------------------------
	// Two-flop synchroniser plus edge history
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign lvl = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

/* File: rtl/sq_slave_dev.sv */
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Own address write acked: status 60, receive.
// - Lost arbitration, own write: ack, status 68.
// - General call acked: status 70, receive.
// - Lost arbitration, general call: status 78.
// - Driver writes 24 to setter to retry.
// - Own data byte acked: status 80, byte kept.
// - Driver writes 0C to clearer for nack.
// - Own data byte nacked: status 88, unaddressed.
// - General call first byte: status 90, saved.
// - General call byte nacked: status 98, unaddressed.
// - Stop or restart while addressed: status A0.
// - Own address read acked: status A8, transmit.
// - Lost arbitration, own read: ack, status B0.
// - Sent byte acked: status B8, send more.
// - Sent byte nacked: status C0, unaddressed.
// - Last byte acked without ack enable: C8.
// - Driver ends each service clearing flag (08).
// - Driver sets ack enable (04) before clearing.
// - Driver loads outgoing byte before clearing flag.
// - Driver reads received byte before clearing flag.
// - Bus error status 00; 14 releases bus.
module sq_slave_dev (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port toward the driver
	sq_reg_if.dev rp,
	// Two-wire bus, open drain
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Addressing setup
	input wire logic [6:0] own_addr,
	input wire logic gc_enable
);
	// Byte sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_ADDR = 4'h1,
		S_AACK = 4'h2,
		S_RX = 4'h3,
		S_RACK = 4'h4,
		S_TX = 4'h5,
		S_TACK = 4'h6,
		S_HOLD = 4'h7,
		S_ERR = 4'h8
	} sq_dev_state_t;

	logic scl_lvl, scl_rise, scl_fall; // Clock line view
	logic sda_lvl, sda_rise, sda_fall; // Data line view
	logic start_c, stop_c; // Bus conditions
	logic addressed; // Inside an addressed transfer
	logic midbyte; // Address byte partly shifted
	sq_dev_state_t state_r; // Current state
	sq_dev_state_t next_r; // State after the hold
	logic [7:0] shreg_r; // Shift register
	logic [7:0] pend_r; // Code to report after ack bit
	logic [7:0] status_r; // Reported status
	logic [7:0] buf_r; // Byte buffer
	logic [7:0] ctrl_v; // Control read-back
	logic [3:0] bitcnt_r; // Bits of current byte
	logic gc_mode_r; // Addressed by general call
	logic mack_r; // Master acked our byte
	logic raise_r; // Pulse: raise the flag
	logic store_r; // Pulse: keep received byte
	logic sda_oe_r, scl_oe_r; // Line pull-downs
	logic flag_r, ack_en_r, halt_r, begin_r, en_r; // Control bits

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	sq_pin_sync u_scl (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_i(scl_i),
		.lvl(scl_lvl),
		.rise(scl_rise),
		.fall(scl_fall)
	);
	sq_pin_sync u_sda (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_i(sda_i),
		.lvl(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// Start and stop seen with clock high
	assign start_c = sda_fall && scl_lvl;
	assign stop_c = sda_rise && scl_lvl;
	assign addressed = (state_r == S_AACK) || (state_r == S_RX) || (state_r == S_RACK) ||
		(state_r == S_TX) || (state_r == S_TACK);
	assign midbyte = (state_r == S_ADDR) && (bitcnt_r != 4'h0);

	// ----------------------------------------
	// Byte sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_r <= S_IDLE;
			next_r <= S_IDLE;
			shreg_r <= 8'h00;
			pend_r <= sq_pkg::ST_NO_INFO;
			status_r <= sq_pkg::ST_NO_INFO;
			bitcnt_r <= 4'h0;
			gc_mode_r <= 1'b0;
			mack_r <= 1'b0;
			raise_r <= 1'b0;
			store_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			raise_r <= 1'b0;
			store_r <= 1'b0;
			if (!en_r) begin
				// Disabled: ignore the bus
				state_r <= S_IDLE;
				sda_oe_r <= 1'b0;
			end else if (halt_r) begin
				// Recovery releases both lines
				state_r <= S_IDLE;
				sda_oe_r <= 1'b0;
				status_r <= sq_pkg::ST_NO_INFO;
			end else if (state_r != S_ERR && state_r != S_HOLD && (start_c || stop_c)) begin
				sda_oe_r <= 1'b0;
				bitcnt_r <= 4'h0;
				if (midbyte) begin
					// Condition inside the address byte
					status_r <= sq_pkg::ST_BUS_ERR;
					raise_r <= 1'b1;
					state_r <= S_ERR;
				end else begin
					if (addressed) begin
						status_r <= sq_pkg::ST_STOP;
						raise_r <= 1'b1;
					end
					state_r <= start_c ? S_ADDR : S_IDLE;
				end
			end else begin
				case (state_r)
					S_ADDR: begin
						if (scl_rise) begin
							shreg_r <= {shreg_r[6:0], sda_lvl};
							bitcnt_r <= bitcnt_r + 4'h1;
						end else if (scl_fall && bitcnt_r == 4'h8) begin
							bitcnt_r <= 4'h0;
							if (ack_en_r && shreg_r[7:1] == own_addr) begin
								sda_oe_r <= 1'b1;
								gc_mode_r <= 1'b0;
								state_r <= S_AACK;
								if (shreg_r[0]) begin
									// Pending master request marks lost arbitration
									pend_r <= begin_r ? sq_pkg::ST_ST_ARB : sq_pkg::ST_ST_ADDR;
									next_r <= S_TX;
								end else begin
									pend_r <= begin_r ? sq_pkg::ST_SR_ARB : sq_pkg::ST_SR_ADDR;
									next_r <= S_RX;
								end
							end else if (ack_en_r && gc_enable && shreg_r == sq_pkg::GC_BYTE) begin
								sda_oe_r <= 1'b1;
								gc_mode_r <= 1'b1;
								state_r <= S_AACK;
								pend_r <= begin_r ? sq_pkg::ST_GC_ARB : sq_pkg::ST_GC_ADDR;
								next_r <= S_RX;
							end else begin
								// Not for us
								state_r <= S_IDLE;
							end
						end
					end
					S_AACK, S_RACK: begin
						// Ack bit done: report and stretch
						if (scl_fall) begin
							sda_oe_r <= 1'b0;
							status_r <= pend_r;
							raise_r <= 1'b1;
							state_r <= S_HOLD;
						end
					end
					S_RX: begin
						if (scl_rise) begin
							shreg_r <= {shreg_r[6:0], sda_lvl};
							bitcnt_r <= bitcnt_r + 4'h1;
						end else if (scl_fall && bitcnt_r == 4'h8) begin
							bitcnt_r <= 4'h0;
							state_r <= S_RACK;
							if (ack_en_r) begin
								sda_oe_r <= 1'b1;
								store_r <= 1'b1;
								pend_r <= gc_mode_r ? sq_pkg::ST_GC_ACK : sq_pkg::ST_SR_ACK;
								next_r <= S_RX;
							end else begin
								// Byte dropped, leave addressed mode
								pend_r <= gc_mode_r ? sq_pkg::ST_GC_NACK : sq_pkg::ST_SR_NACK;
								next_r <= S_IDLE;
							end
						end
					end
					S_TX: begin
						// Data changes only while clock is low
						if (scl_fall) begin
							if (bitcnt_r == 4'h7) begin
								sda_oe_r <= 1'b0;
								bitcnt_r <= 4'h0;
								state_r <= S_TACK;
							end else begin
								shreg_r <= {shreg_r[6:0], 1'b0};
								sda_oe_r <= ~shreg_r[6];
								bitcnt_r <= bitcnt_r + 4'h1;
							end
						end
					end
					S_TACK: begin
						if (scl_rise) begin
							mack_r <= ~sda_lvl;
						end else if (scl_fall) begin
							raise_r <= 1'b1;
							state_r <= S_HOLD;
							if (!mack_r) begin
								status_r <= sq_pkg::ST_ST_NACK;
								next_r <= S_IDLE;
							end else if (ack_en_r) begin
								status_r <= sq_pkg::ST_ST_ACK;
								next_r <= S_TX;
							end else begin
								status_r <= sq_pkg::ST_ST_LAST;
								next_r <= S_IDLE;
							end
						end
					end
					S_HOLD: begin
						// Resume once the driver has cleared the flag
						if (!flag_r && !raise_r) begin
							state_r <= next_r;
							status_r <= sq_pkg::ST_NO_INFO;
							bitcnt_r <= 4'h0;
							if (next_r == S_TX) begin
								shreg_r <= buf_r;
								sda_oe_r <= ~buf_r[7];
							end
						end
					end
					S_IDLE, S_ERR: begin
						// Wait for a start or for recovery
					end
					default: begin
						state_r <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// State-change flag: hardware set beats clear
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			flag_r <= 1'b0;
		end else if (raise_r) begin
			flag_r <= 1'b1;
		end else if (rp.clr_stb && rp.wdata[sq_pkg::CB_FLAG]) begin
			flag_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control bits from setter and clearer
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_en_r <= 1'b0;
			begin_r <= 1'b0;
			en_r <= 1'b0;
			halt_r <= 1'b0;
		end else begin
			// Halt acts once and clears itself
			halt_r <= rp.set_stb && rp.wdata[sq_pkg::CB_HALT];
			if (rp.set_stb && rp.wdata[sq_pkg::CB_ACK]) begin
				ack_en_r <= 1'b1;
			end else if (rp.clr_stb && rp.wdata[sq_pkg::CB_ACK]) begin
				ack_en_r <= 1'b0;
			end
			// No master logic here, so a stop consumes the request
			if (rp.set_stb && rp.wdata[sq_pkg::CB_BEGIN]) begin
				begin_r <= 1'b1;
			end else if ((rp.clr_stb && rp.wdata[sq_pkg::CB_BEGIN]) || stop_c) begin
				begin_r <= 1'b0;
			end
			if (rp.set_stb && rp.wdata[sq_pkg::CB_EN]) begin
				en_r <= 1'b1;
			end else if (rp.clr_stb && rp.wdata[sq_pkg::CB_EN]) begin
				en_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Byte buffer: received byte or driver load
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			buf_r <= 8'h00;
		end else if (store_r) begin
			buf_r <= shreg_r;
		end else if (rp.buf_stb) begin
			buf_r <= rp.wdata;
		end
	end

	// Clock stretch follows the hold state
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scl_oe_r <= 1'b0;
		end else begin
			scl_oe_r <= (state_r == S_HOLD);
		end
	end

	// Control read-back image
	always_comb begin
		ctrl_v = 8'h00;
		ctrl_v[sq_pkg::CB_ACK] = ack_en_r;
		ctrl_v[sq_pkg::CB_FLAG] = flag_r;
		ctrl_v[sq_pkg::CB_HALT] = halt_r;
		ctrl_v[sq_pkg::CB_BEGIN] = begin_r;
		ctrl_v[sq_pkg::CB_EN] = en_r;
	end

	// Open drain: only the enables move
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_r;
	assign sda_oe = sda_oe_r;
	assign rp.status = status_r;
	assign rp.rbyte = buf_r;
	assign rp.flag = flag_r;
	assign rp.ctrl = ctrl_v;
endmodule
`default_nettype wire

/* File: rtl/sq_drv_end.sv */
`timescale 1ns/10ps
`default_nettype none
module sq_drv_end #(
	parameter int DEPTH = 16 // Bytes per transfer buffer
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// AXI4-Lite write channels
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register port toward the controller
	sq_reg_if.drv rp
);
	localparam int PW = $clog2(DEPTH);
	// Service sequencer states
	typedef enum logic [2:0] {
		D_OFF = 3'h0,
		D_IDLE = 3'h1,
		D_BUF = 3'h2,
		D_SET = 3'h3,
		D_CLR = 3'h4,
		D_GAP = 3'h5
	} sq_drv_state_t;

	logic [7:0] tx_mem [DEPTH]; // Outgoing bytes
	logic [7:0] rx_mem [DEPTH]; // Received bytes
	logic [PW-1:0] tx_fill_r, tx_ptr_r, rx_wr_r, rx_rd_r; // Ring pointers
	logic [15:0] hctrl_r; // Enable and receive limit
	logic wr_hs_r, bvalid_r, ar_hs_r, rvalid_r; // Channel state
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	sq_drv_state_t st_r; // Service state
	logic [7:0] last_st_r, rx_cnt_r, set_v_r, clr_v_r, wd_r;
	logic load_r, set_stb_r, clr_stb_r, buf_stb_r;
	logic keep_c; // Status carries a byte to keep

	// Known register offset
	function automatic logic known(input logic [3:0] a);
		known = (a == sq_pkg::A_CTRL) || (a == sq_pkg::A_STAT) ||
			(a == sq_pkg::A_TXD) || (a == sq_pkg::A_RXD);
	endfunction

	assign keep_c = (rp.status == sq_pkg::ST_SR_ACK) || (rp.status == sq_pkg::ST_GC_ACK);

	// ----------------------------------------
	// AXI write: both channels taken together
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wr_hs_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= sq_pkg::RESP_OK;
			hctrl_r <= sq_pkg::HCTRL_RST;
			tx_fill_r <= '0;
		end else begin
			wr_hs_r <= awvalid && wvalid && !wr_hs_r && !bvalid_r;
			if (wr_hs_r) begin
				bvalid_r <= 1'b1;
				bresp_r <= known(awaddr) ? sq_pkg::RESP_OK : sq_pkg::RESP_DECERR;
				if (awaddr == sq_pkg::A_CTRL) begin
					if (wstrb[0]) hctrl_r[7:0] <= wdata[7:0];
					if (wstrb[1]) hctrl_r[15:8] <= wdata[15:8];
				end else if (awaddr == sq_pkg::A_TXD && wstrb[0]) begin
					tx_fill_r <= tx_fill_r + PW'(1);
				end
			end else if (bvalid_r && bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Outgoing byte store, no reset needed
	always_ff @(posedge sys_clk) begin
		if (wr_hs_r && awaddr == sq_pkg::A_TXD && wstrb[0]) begin
			tx_mem[tx_fill_r] <= wdata[7:0];
		end
	end

	// ----------------------------------------
	// AXI read: reading RXD pops one byte
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ar_hs_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= sq_pkg::RESP_OK;
			rdata_r <= 32'h0000_0000;
			rx_rd_r <= '0;
		end else begin
			ar_hs_r <= arvalid && !ar_hs_r && !rvalid_r;
			if (ar_hs_r) begin
				rvalid_r <= 1'b1;
				rresp_r <= known(araddr) ? sq_pkg::RESP_OK : sq_pkg::RESP_DECERR;
				case (araddr)
					sq_pkg::A_CTRL: rdata_r <= {16'h0000, hctrl_r};
					sq_pkg::A_STAT: rdata_r <= {8'h00, rx_cnt_r, rp.ctrl, last_st_r};
					sq_pkg::A_RXD: begin
						rdata_r <= {24'h00_0000, rx_mem[rx_rd_r]};
						rx_rd_r <= rx_rd_r + PW'(1);
					end
					default: rdata_r <= 32'h0000_0000;
				endcase
			end else if (rvalid_r && rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Received byte store while servicing
	always_ff @(posedge sys_clk) begin
		if (st_r == D_IDLE && rp.flag && keep_c) begin
			rx_mem[rx_wr_r] <= rp.rbyte;
		end
	end

	// ----------------------------------------
	// Status service: buffer, set, then clear
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			st_r <= D_OFF;
			set_stb_r <= 1'b0;
			clr_stb_r <= 1'b0;
			buf_stb_r <= 1'b0;
			wd_r <= 8'h00;
			set_v_r <= sq_pkg::CV_NONE;
			clr_v_r <= sq_pkg::CV_FLAG;
			load_r <= 1'b0;
			last_st_r <= sq_pkg::ST_NO_INFO;
			rx_cnt_r <= 8'h00;
			rx_wr_r <= '0;
			tx_ptr_r <= '0;
		end else begin
			set_stb_r <= 1'b0;
			clr_stb_r <= 1'b0;
			buf_stb_r <= 1'b0;
			case (st_r)
				D_OFF: begin
					if (hctrl_r[sq_pkg::HC_EN]) begin
						set_stb_r <= 1'b1;
						wd_r <= sq_pkg::CV_INIT;
						st_r <= D_GAP;
					end
				end
				D_IDLE: begin
					if (!hctrl_r[sq_pkg::HC_EN]) begin
						clr_stb_r <= 1'b1;
						wd_r <= sq_pkg::CV_INIT;
						st_r <= D_OFF;
					end else if (rp.flag) begin
						last_st_r <= rp.status;
						load_r <= 1'b0;
						set_v_r <= sq_pkg::CV_ACK;
						clr_v_r <= sq_pkg::CV_FLAG;
						st_r <= D_BUF;
						case (rp.status)
							sq_pkg::ST_BUS_ERR: set_v_r <= sq_pkg::CV_HALT_AA;
							sq_pkg::ST_SR_ADDR, sq_pkg::ST_GC_ADDR: rx_cnt_r <= 8'h00;
							sq_pkg::ST_SR_ARB, sq_pkg::ST_GC_ARB: begin
								rx_cnt_r <= 8'h00;
								set_v_r <= sq_pkg::CV_BEGIN_AA;
							end
							sq_pkg::ST_SR_ACK: begin
								rx_wr_r <= rx_wr_r + PW'(1);
								rx_cnt_r <= rx_cnt_r + 8'h01;
								// Limit reached: nack the next byte
								if (rx_cnt_r + 8'h01 == hctrl_r[15:8]) begin
									set_v_r <= sq_pkg::CV_NONE;
									clr_v_r <= sq_pkg::CV_AA_FLAG;
								end
							end
							sq_pkg::ST_GC_ACK: begin
								rx_wr_r <= rx_wr_r + PW'(1);
								set_v_r <= sq_pkg::CV_NONE;
								clr_v_r <= sq_pkg::CV_AA_FLAG;
							end
							sq_pkg::ST_ST_ADDR, sq_pkg::ST_ST_ARB, sq_pkg::ST_ST_ACK: begin
								load_r <= 1'b1;
								if (rp.status == sq_pkg::ST_ST_ARB) begin
									set_v_r <= sq_pkg::CV_BEGIN_AA;
								end
								// Last queued byte goes out with ack disabled
								if (tx_ptr_r + PW'(1) == tx_fill_r) begin
									set_v_r <= sq_pkg::CV_NONE;
									clr_v_r <= sq_pkg::CV_AA_FLAG;
								end
							end
							default: begin
							end
						endcase
					end
				end
				D_BUF: begin
					if (load_r) begin
						buf_stb_r <= 1'b1;
						wd_r <= tx_mem[tx_ptr_r];
						tx_ptr_r <= tx_ptr_r + PW'(1);
					end
					st_r <= D_SET;
				end
				D_SET: begin
					if (set_v_r != sq_pkg::CV_NONE) begin
						set_stb_r <= 1'b1;
						wd_r <= set_v_r;
					end
					st_r <= D_CLR;
				end
				D_CLR: begin
					clr_stb_r <= 1'b1;
					wd_r <= clr_v_r;
					st_r <= D_GAP;
				end
				D_GAP: st_r <= D_IDLE;
				default: st_r <= D_OFF;
			endcase
		end
	end

	assign awready = wr_hs_r;
	assign wready = wr_hs_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = ar_hs_r;
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = rdata_r;
	assign rp.set_stb = set_stb_r;
	assign rp.clr_stb = clr_stb_r;
	assign rp.buf_stb = buf_stb_r;
	assign rp.wdata = wd_r;
endmodule
`default_nettype wire

/* File: sim/sq_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sq_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register port signals
	input wire logic set_stb,
	input wire logic clr_stb,
	input wire logic buf_stb,
	input wire logic [7:0] wdata,
	input wire logic [7:0] status,
	input wire logic [7:0] rbyte,
	input wire logic [7:0] ctrl,
	input wire logic flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// ----------------------------------------
	// Strobes and their effect
	// ----------------------------------------
	chk_flag_clear: assert property (clr_stb && wdata[3] |=> !flag)
		else $error("Flag not cleared");
	chk_ack_set: assert property (set_stb && wdata[2] |=> ctrl[2])
		else $error("Ack enable not set");
	chk_ack_drop: assert property (clr_stb && wdata[2] && !set_stb |=> !ctrl[2])
		else $error("Ack enable not cleared");
	chk_begin_set: assert property (set_stb && wdata[5] |=> ctrl[5])
		else $error("Begin request not set");
	chk_halt_pulse: assert property (ctrl[4] |=> !ctrl[4])
		else $error("Halt request stays");
	chk_buf_load: assert property (buf_stb |=> rbyte == $past(wdata))
		else $error("Byte buffer not loaded");
	// ----------------------------------------
	// Status and flag service
	// ----------------------------------------
	chk_status_known: assert property ($rose(flag) |=> status != sq_pkg::ST_NO_INFO)
		else $error("Flag without status");
	// Driver must end every service within its short sequence
	chk_flag_served: assert property ($rose(flag) |-> ##[1:12] (clr_stb && wdata[3]))
		else $error("Flag left unserved");
	// Received byte must not move while the driver reads it
	chk_rx_stable: assert property (flag && !buf_stb |=> $stable(rbyte))
		else $error("Byte buffer moved");
	cover property (flag && status == sq_pkg::ST_SR_ACK);
	cover property (flag && status == sq_pkg::ST_ST_LAST);
	cover property (flag && status == sq_pkg::ST_STOP);
endmodule
`default_nettype wire

/* File: sim/i2c_slave_state_sequencer_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_state_sequencer_tb;
	logic sys_clk, reset, awvalid, wvalid, bready, arvalid, rready, m_scl, m_sda, ak;
	logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe;
	logic [3:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rr;
	logic [7:0] rb;
	int errors, tests_run;
	wire scl, sda;
	sq_reg_if rp_if();
	// Open-drain wires, pulled up when nobody pulls low
	assign scl = m_scl & ~scl_oe;
	assign sda = m_sda & ~sda_oe;
	sq_slave_dev i_sq_slave_dev (.sys_clk(sys_clk), .reset(reset), .rp(rp_if),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.own_addr(7'h2a), .gc_enable(1'b1));
	sq_drv_end #(.DEPTH(4)) i_sq_drv_end (.sys_clk(sys_clk), .reset(reset), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rp(rp_if));
	sq_checker i_sq_checker (.sys_clk(sys_clk), .reset(reset), .set_stb(rp_if.set_stb),
		.clr_stb(rp_if.clr_stb), .buf_stb(rp_if.buf_stb), .wdata(rp_if.wdata),
		.status(rp_if.status), .rbyte(rp_if.rbyte), .ctrl(rp_if.ctrl), .flag(rp_if.flag));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		do @(posedge sys_clk); while (awready !== 1'b1);
		{awvalid, wvalid} <= 2'h0;
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [3:0] a);
		@(posedge sys_clk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		{rd, rr} = {rdata, rresp};
		rready <= 1'b0;
	endtask
	// One bus bit; waits out clock stretching by the slave
	task automatic bit_x(input logic b, output logic s);
		#32 m_sda <= b;
		#32 m_scl <= 1'b1;
		#1;
		while (scl !== 1'b1) @(posedge sys_clk);
		#60 s = sda;
		m_scl <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic mack);
		for (int i = 7; i >= 0; i--) bit_x(d[i], rb[i]);
		bit_x(mack, ak);
	endtask
	task automatic start_c;
		#36 m_sda <= 1'b1;
		#36 m_scl <= 1'b1;
		#36 m_sda <= 1'b0;
		#36 m_scl <= 1'b0;
	endtask
	task automatic stop_c;
		#36 m_sda <= 1'b0;
		#36 m_scl <= 1'b1;
		#1;
		while (scl !== 1'b1) @(posedge sys_clk);
		#36 m_sda <= 1'b1;
		#72;
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, tests
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	// A hung handshake or stretch ends here
	initial begin
		#400000;
		errors++;
		complete_run;
	end
	initial begin
		{reset, m_scl, m_sda} = 3'h7;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = '0;
		errors = 0;
		tests_run = 0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		axw(4'h0, 32'h1);
		// Own address write, one byte, stop while addressed
		start_c;
		xfer(8'h54, 1'b1);
		chk({7'h0, ak}, 8'h0);
		xfer(8'ha5, 1'b1);
		chk({7'h0, ak}, 8'h0);
		stop_c;
		axr(4'h4);
		chk(rd[7:0], sq_pkg::ST_STOP);
		axr(4'hc);
		chk(rd[7:0], 8'ha5);
		$display("own write test done");
		// Own address read, two queued bytes, last one acked
		axw(4'h8, 32'h3c);
		axw(4'h8, 32'hc3);
		start_c;
		xfer(8'h55, 1'b1);
		chk({7'h0, ak}, 8'h0);
		xfer(8'hff, 1'b0);
		chk(rb, 8'h3c);
		xfer(8'hff, 1'b0);
		chk(rb, 8'hc3);
		stop_c;
		axr(4'h4);
		chk(rd[7:0], sq_pkg::ST_ST_LAST);
		$display("own read test done");
		// General call: first byte kept, second refused
		start_c;
		xfer(8'h00, 1'b1);
		chk({7'h0, ak}, 8'h0);
		xfer(8'h11, 1'b1);
		chk({7'h0, ak}, 8'h0);
		xfer(8'h22, 1'b1);
		chk({7'h0, ak}, 8'h1);
		stop_c;
		axr(4'h4);
		chk(rd[7:0], sq_pkg::ST_GC_NACK);
		axr(4'hc);
		chk(rd[7:0], 8'h11);
		$display("general call test done");
		// Receive limit of one: second byte refused
		axw(4'h0, 32'h101);
		start_c;
		xfer(8'h54, 1'b1);
		xfer(8'h5a, 1'b1);
		xfer(8'h66, 1'b1);
		chk({7'h0, ak}, 8'h1);
		stop_c;
		axr(4'h4);
		chk(rd[7:0], sq_pkg::ST_SR_NACK);
		chk(rd[23:16], 8'h01);
		axr(4'hc);
		chk(rd[7:0], 8'h5a);
		// Master refuses the only queued byte
		axw(4'h8, 32'h77);
		start_c;
		xfer(8'h55, 1'b1);
		xfer(8'hff, 1'b1);
		chk(rb, 8'h77);
		stop_c;
		axr(4'h4);
		chk(rd[7:0], sq_pkg::ST_ST_NACK);
		$display("refused byte test done");
		// Foreign address ignored, then an unmapped offset
		start_c;
		xfer(8'h26, 1'b1);
		chk({7'h0, ak}, 8'h1);
		stop_c;
		axr(4'h2);
		chk({6'h0, rr}, {6'h0, sq_pkg::RESP_DECERR});
		$display("refusal test done");
		complete_run;
	end
endmodule
`default_nettype wire
